// File: pie_regs.vh
// Register map, reset values and field positions for the port and edge interrupt block
// Summary of operation
// [RULE_01] A port-1 line is an input while its direction bit is 1 and a push-pull output of its latch while 0.
// [RULE_02] Chip reset sets every port-1 direction bit to 1, so all port-1 lines start as inputs.
// [RULE_03] A port-1 line raises an external interrupt only while its enable bit is set and it is an input.
// [RULE_04] Port-1 lines 0 to 3 feed interrupt source two and lines 4 to 7 feed interrupt source three.
// [RULE_05] A falling edge on interrupt source three sets flag bit 1 of the event flag register.
// [RULE_06] A falling edge on interrupt source two sets flag bit 0 of the event flag register.
// [RULE_07] Flag bit 2 is set while any caller-ID event flag is set.
// [RULE_08] Flag bit 4 is set when the comparator result bit rises from low to high.
// [RULE_09] Flag bit 3 marks a divider overflow and bits 7 to 5 are unused and read zero.
// [RULE_10] A falling edge on a port-1 pin sets its status bit, which holds until software clears it; reset is zero.
// [RULE_11] Each pull-up enable bit of ports 2, 3 and 4 turns the pull-up on when 1, and all reset to zero.
// [RULE_12] Port 2 has pull-ups and per-bit direction, a 0 direction bit making the line a push-pull output.
// [RULE_13] After reset every port-2 line is an input and the port-2 data register reads all ones.
// [RULE_14] The port-4 direction register resets to all ones and all zeros makes every line an output.
// [RULE_15] Port 4 is bidirectional with pull-ups and its data register resets to all ones.
// [RULE_16] Edge inputs are synchronised to the clock and an edge is a one followed by a zero sample.
`ifndef PIE_REGS_VH
`define PIE_REGS_VH
`define PIE_ADDR_P1_DATA    8'h90
`define PIE_ADDR_P1_DIR     8'h91
`define PIE_ADDR_P1_IRQEN   8'h94
`define PIE_ADDR_EVT_FLAGS  8'h95
`define PIE_ADDR_P1_STATUS  8'h93
`define PIE_ADDR_P2_PULLUP  8'h9e
`define PIE_ADDR_P3_PULLUP  8'h9f
`define PIE_ADDR_P2_DATA    8'ha0
`define PIE_ADDR_P2_DIR     8'ha3
`define PIE_ADDR_P4_PULLUP  8'ha2
`define PIE_ADDR_P3_DATA    8'ha4
`define PIE_ADDR_P4_DATA    8'ha6
`define PIE_ADDR_P4_DIR     8'hae
`define PIE_ADDR_IRQ_MASK   8'ha7
`define PIE_RST_DATA        8'hff
`define PIE_RST_DIR         8'hff
`define PIE_RST_ZERO        8'h00
`define PIE_RST_P1_DATA     8'hff
`define PIE_FLAG_IRQ2       0
`define PIE_FLAG_IRQ3       1
`define PIE_FLAG_CID        2
`define PIE_FLAG_DIV        3
`define PIE_FLAG_COMP       4
`define PIE_FLAG_MASK       8'h1f
`endif

// File: pie_port_io.v
// Ports 1 to 4 with direction, pull-up, edge status and event flag logic
`include "pie_regs.vh"
module pie_port_io (
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       nrst_i,
    // Register port
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // Port 1 pins
    input  wire [7:0] port_one_pin_i,
    output wire [7:0] port_one_pin_o,
    output wire [7:0] port_one_pin_oe_o,
    // Port 2 pins
    input  wire [7:0] port_two_pin_i,
    output wire [7:0] port_two_pin_o,
    output wire [7:0] port_two_pin_oe_o,
    output wire [7:0] port_two_pullup_o,
    // Port 3 pins
    input  wire [7:0] port_three_pin_i,
    output wire [7:0] port_three_pin_o,
    output wire [7:0] port_three_pin_oe_o,
    output wire [7:0] port_three_pullup_o,
    // Port 4 pins
    input  wire [7:0] port_four_pin_i,
    output wire [7:0] port_four_pin_o,
    output wire [7:0] port_four_pin_oe_o,
    output wire [7:0] port_four_pullup_o,
    // Event sources
    input  wire [4:0] caller_id_event_flag_i,
    input  wire       comparator_result_bit_i,
    input  wire       divider_overflow_flag_i,
    // Interrupt
    output wire       irq_o
);

    reg  [7:0] port_one_data;
    reg  [7:0] port_one_direction;
    reg  [7:0] port_one_irq_enable;
    reg  [7:0] port_one_edge_status;
    reg  [7:0] port_two_data;
    reg  [7:0] port_two_direction;
    reg  [7:0] port_two_pullup_enable;
    reg  [7:0] port_three_data;
    reg  [7:0] port_three_pullup_enable;
    reg  [7:0] port_four_data;
    reg  [7:0] port_four_direction;
    reg  [7:0] port_four_pullup_enable;
    reg  [7:0] external_event_flags;
    reg  [7:0] irq_mask;
    reg  [7:0] p1_sync_a;
    reg  [7:0] p1_sync_b;
    reg  [7:0] p1_prev;
    reg        comp_prev;
    wire [7:0] p1_fall;
    wire [7:0] p1_src;
    wire       ext_irq_source_two;
    wire       ext_irq_source_three;
    reg        src2_prev;
    reg        src3_prev;
    wire [7:0] evt_set;
    reg  [7:0] next_rdata;
    wire [7:0] p1_view;
    wire [7:0] p2_view;
    wire [7:0] p4_view;

    // Port 3 is quasi-bidirectional: a latch bit of 1 lets the pin float high
    assign port_one_pin_o      = port_one_data;
    assign port_one_pin_oe_o   = ~port_one_direction; // [RULE_01]
    assign port_two_pin_o      = port_two_data;
    assign port_two_pin_oe_o   = ~port_two_direction; // [RULE_12]
    assign port_two_pullup_o   = port_two_pullup_enable; // [RULE_11]
    assign port_three_pin_o    = port_three_data;
    assign port_three_pin_oe_o = ~port_three_data;
    assign port_three_pullup_o = port_three_pullup_enable; // [RULE_11]
    assign port_four_pin_o     = port_four_data;
    assign port_four_pin_oe_o  = ~port_four_direction; // [RULE_14]
    assign port_four_pullup_o  = port_four_pullup_enable; // [RULE_11] [RULE_15]

    assign p1_fall = p1_prev & ~p1_sync_b; // [RULE_16]
    // A line takes part only as an enabled input; idle level is high
    assign p1_src = p1_sync_b | ~(port_one_irq_enable & port_one_direction); // [RULE_03]
    assign ext_irq_source_two   = &p1_src[3:0]; // [RULE_04]
    assign ext_irq_source_three = &p1_src[7:4]; // [RULE_04]

    assign evt_set[`PIE_FLAG_IRQ2] = src2_prev & ~ext_irq_source_two; // [RULE_06]
    assign evt_set[`PIE_FLAG_IRQ3] = src3_prev & ~ext_irq_source_three; // [RULE_05]
    assign evt_set[`PIE_FLAG_CID]  = |caller_id_event_flag_i; // [RULE_07]
    assign evt_set[`PIE_FLAG_DIV]  = divider_overflow_flag_i; // [RULE_09]
    assign evt_set[`PIE_FLAG_COMP] = comparator_result_bit_i & ~comp_prev; // [RULE_08]
    assign evt_set[7:5] = 3'h0; // [RULE_09]

    assign irq_o = |(external_event_flags & irq_mask);

    // Two-flop synchroniser; only the second stage is read elsewhere
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_sync_a <= 8'hff;
            p1_sync_b <= 8'hff;
        end else begin
            p1_sync_a <= port_one_pin_i; // [RULE_16]
            p1_sync_b <= p1_sync_a;
        end
    end

    // History resets high, the idle pin level
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_prev <= 8'hff;
        end else begin
            p1_prev <= p1_sync_b; // [RULE_16]
        end
    end

    // Source history for the grouped interrupt edges
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src2_prev <= 1'b1;
            src3_prev <= 1'b1;
        end else begin
            src2_prev <= ext_irq_source_two;
            src3_prev <= ext_irq_source_three;
        end
    end

    // Comparator history; the input is already synchronous
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            comp_prev <= 1'b0;
        end else begin
            comp_prev <= comparator_result_bit_i;
        end
    end

    // One-hot write select; each register owns its own flop process
    localparam SEL_P1_DATA   = 0;
    localparam SEL_P1_DIR    = 1;
    localparam SEL_P1_IRQEN  = 2;
    localparam SEL_P1_STATUS = 3;
    localparam SEL_EVT_FLAGS = 4;
    localparam SEL_IRQ_MASK  = 5;
    localparam SEL_P2_DATA   = 6;
    localparam SEL_P2_DIR    = 7;
    localparam SEL_P2_PULLUP = 8;
    localparam SEL_P3_DATA   = 9;
    localparam SEL_P3_PULLUP = 10;
    localparam SEL_P4_DATA   = 11;
    localparam SEL_P4_DIR    = 12;
    localparam SEL_P4_PULLUP = 13;
    reg  [13:0] wr_sel;

    always @* begin
        wr_sel = 14'h0000;
        if (wr_i) begin
            if (addr_i == `PIE_ADDR_P1_DATA) begin
                wr_sel[SEL_P1_DATA] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P1_DIR) begin
                wr_sel[SEL_P1_DIR] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P1_IRQEN) begin
                wr_sel[SEL_P1_IRQEN] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P1_STATUS) begin
                wr_sel[SEL_P1_STATUS] = 1'b1;
            end else if (addr_i == `PIE_ADDR_EVT_FLAGS) begin
                wr_sel[SEL_EVT_FLAGS] = 1'b1;
            end else if (addr_i == `PIE_ADDR_IRQ_MASK) begin
                wr_sel[SEL_IRQ_MASK] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P2_DATA) begin
                wr_sel[SEL_P2_DATA] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P2_DIR) begin
                wr_sel[SEL_P2_DIR] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P2_PULLUP) begin
                wr_sel[SEL_P2_PULLUP] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P3_DATA) begin
                wr_sel[SEL_P3_DATA] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P3_PULLUP) begin
                wr_sel[SEL_P3_PULLUP] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P4_DATA) begin
                wr_sel[SEL_P4_DATA] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P4_DIR) begin
                wr_sel[SEL_P4_DIR] = 1'b1;
            end else if (addr_i == `PIE_ADDR_P4_PULLUP) begin
                wr_sel[SEL_P4_PULLUP] = 1'b1;
            end
        end
    end

    // Port-1 output latch
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_one_data <= `PIE_RST_P1_DATA;
        end else if (wr_sel[SEL_P1_DATA]) begin
            port_one_data <= wdata_i;
        end
    end

    // Port-1 direction, all inputs after reset
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_one_direction <= `PIE_RST_DIR; // [RULE_02]
        end else if (wr_sel[SEL_P1_DIR]) begin
            port_one_direction <= wdata_i; // [RULE_01]
        end
    end

    // Interrupt enable per port-1 line
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_one_irq_enable <= `PIE_RST_ZERO;
        end else if (wr_sel[SEL_P1_IRQEN]) begin
            port_one_irq_enable <= wdata_i; // [RULE_03]
        end
    end

    // Mask keeps only the five defined flags
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_mask <= `PIE_RST_ZERO;
        end else if (wr_sel[SEL_IRQ_MASK]) begin
            irq_mask <= wdata_i & `PIE_FLAG_MASK;
        end
    end

    // Port-2 latch
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_two_data <= `PIE_RST_DATA; // [RULE_13]
        end else if (wr_sel[SEL_P2_DATA]) begin
            port_two_data <= wdata_i;
        end
    end

    // Port-2 direction
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_two_direction <= `PIE_RST_DIR; // [RULE_13]
        end else if (wr_sel[SEL_P2_DIR]) begin
            port_two_direction <= wdata_i; // [RULE_12]
        end
    end

    // Port-2 pull-ups, off after reset
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_two_pullup_enable <= `PIE_RST_ZERO; // [RULE_11]
        end else if (wr_sel[SEL_P2_PULLUP]) begin
            port_two_pullup_enable <= wdata_i;
        end
    end

    // Port-3 latch doubles as its drive enable
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_three_data <= `PIE_RST_DATA;
        end else if (wr_sel[SEL_P3_DATA]) begin
            port_three_data <= wdata_i;
        end
    end

    // Port-3 pull-ups
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_three_pullup_enable <= `PIE_RST_ZERO; // [RULE_11]
        end else if (wr_sel[SEL_P3_PULLUP]) begin
            port_three_pullup_enable <= wdata_i;
        end
    end

    // Port-4 latch
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_four_data <= `PIE_RST_DATA; // [RULE_15]
        end else if (wr_sel[SEL_P4_DATA]) begin
            port_four_data <= wdata_i;
        end
    end

    // Port-4 direction
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_four_direction <= `PIE_RST_DIR; // [RULE_14]
        end else if (wr_sel[SEL_P4_DIR]) begin
            port_four_direction <= wdata_i; // [RULE_14]
        end
    end

    // Port-4 pull-ups
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_four_pullup_enable <= `PIE_RST_ZERO; // [RULE_11]
        end else if (wr_sel[SEL_P4_PULLUP]) begin
            port_four_pullup_enable <= wdata_i;
        end
    end

    // Per-line logic: read view, sticky status, event flags
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
            // Input lines read the pin, output lines their latch
            assign p1_view[gi] = port_one_direction[gi] ? p1_sync_b[gi] : port_one_data[gi];
            assign p2_view[gi] = port_two_direction[gi] ? port_two_pin_i[gi] : port_two_data[gi];
            assign p4_view[gi] = port_four_direction[gi] ? port_four_pin_i[gi] : port_four_data[gi];

            // Set wins over a write-one clear in the same cycle
            always @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    port_one_edge_status[gi] <= 1'b0; // [RULE_10]
                end else if (p1_fall[gi]) begin
                    port_one_edge_status[gi] <= 1'b1; // [RULE_10]
                end else if (wr_sel[SEL_P1_STATUS] && wdata_i[gi]) begin
                    port_one_edge_status[gi] <= 1'b0;
                end
            end

            always @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    external_event_flags[gi] <= 1'b0;
                end else if (evt_set[gi]) begin
                    external_event_flags[gi] <= 1'b1;
                end else if (wr_sel[SEL_EVT_FLAGS] && wdata_i[gi]) begin
                    external_event_flags[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Read decode; port-1 pin reads return the synchronised level, ports 2 to 4 the live unsynchronised pin
    always @* begin
        if (addr_i == `PIE_ADDR_P1_DATA) begin
            next_rdata = p1_view; // [RULE_01]
        end else if (addr_i == `PIE_ADDR_P1_DIR) begin
            next_rdata = port_one_direction;
        end else if (addr_i == `PIE_ADDR_P1_IRQEN) begin
            next_rdata = port_one_irq_enable;
        end else if (addr_i == `PIE_ADDR_P1_STATUS) begin
            next_rdata = port_one_edge_status;
        end else if (addr_i == `PIE_ADDR_EVT_FLAGS) begin
            next_rdata = external_event_flags;
        end else if (addr_i == `PIE_ADDR_IRQ_MASK) begin
            next_rdata = irq_mask;
        end else if (addr_i == `PIE_ADDR_P2_DATA) begin
            next_rdata = p2_view; // [RULE_12]
        end else if (addr_i == `PIE_ADDR_P2_DIR) begin
            next_rdata = port_two_direction;
        end else if (addr_i == `PIE_ADDR_P2_PULLUP) begin
            next_rdata = port_two_pullup_enable;
        end else if (addr_i == `PIE_ADDR_P3_DATA) begin
            next_rdata = port_three_data & port_three_pin_i;
        end else if (addr_i == `PIE_ADDR_P3_PULLUP) begin
            next_rdata = port_three_pullup_enable;
        end else if (addr_i == `PIE_ADDR_P4_DATA) begin
            next_rdata = p4_view; // [RULE_15]
        end else if (addr_i == `PIE_ADDR_P4_DIR) begin
            next_rdata = port_four_direction;
        end else if (addr_i == `PIE_ADDR_P4_PULLUP) begin
            next_rdata = port_four_pullup_enable;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule

// File: pie_port_io_properties.sv
// Port-level assertions for the port and edge interrupt block
`include "pie_regs.vh"
module pie_port_io_properties (
    // Clock, reset and register port
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Pin side
    input wire logic [7:0] port_one_pin_o,
    input wire logic [7:0] port_one_pin_oe_o,
    input wire logic [7:0] port_two_pin_oe_o,
    input wire logic [7:0] port_four_pin_oe_o,
    input wire logic [7:0] port_two_pullup_o,
    input wire logic [7:0] port_four_pullup_o,
    input wire logic       irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_p1_drive_sel: assert property (wr_i && addr_i == `PIE_ADDR_P1_DIR |=>
        port_one_pin_oe_o == ~$past(wdata_i)) else $error("port one enable mismatch");
    a_p1_latch_out: assert property (wr_i && addr_i == `PIE_ADDR_P1_DATA |=>
        port_one_pin_o == $past(wdata_i)) else $error("port one latch mismatch");
    a_reset_inputs: assert property ($rose(nrst_i) |->
        (port_one_pin_oe_o | port_two_pin_oe_o | port_four_pin_oe_o) == 8'h00) else $error("driving after reset");
    a_p2_drive_sel: assert property (wr_i && addr_i == `PIE_ADDR_P2_DIR |=>
        port_two_pin_oe_o == ~$past(wdata_i)) else $error("port two enable mismatch");
    a_p4_drive_sel: assert property (wr_i && addr_i == `PIE_ADDR_P4_DIR |=>
        port_four_pin_oe_o == ~$past(wdata_i)) else $error("port four enable mismatch");
    a_p2_pullup_set: assert property (wr_i && addr_i == `PIE_ADDR_P2_PULLUP |=>
        port_two_pullup_o == $past(wdata_i)) else $error("port two pull-up mismatch");
    a_p4_pullup_set: assert property (wr_i && addr_i == `PIE_ADDR_P4_PULLUP |=>
        port_four_pullup_o == $past(wdata_i)) else $error("port four pull-up mismatch");
    a_flag_upper_zero: assert property (rd_i && addr_i == `PIE_ADDR_EVT_FLAGS |=>
        rdata_o[7:5] == 3'h0) else $error("unused flag bits set");
    c_dir_write: cover property (wr_i && addr_i == `PIE_ADDR_P1_DIR);
    c_irq_rise: cover property ($rose(irq_o));
    c_status_read: cover property (rd_i && addr_i == `PIE_ADDR_P1_STATUS);
endmodule

// File: pie_pin_model.sv
// Board side of one 8-bit port: driven level, pull-up or external level
module pie_pin_model (
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_i,
    output wire logic [7:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Push-pull drive wins, then pull-up, else the board level
    assign lvl_o = (oe_i & out_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ext_i);
endmodule

// File: pie_port_io_tb.sv
// Self-checking bench for the port and edge interrupt block
`include "pie_regs.vh"
module pie_port_io_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys_i, nrst_i, wr_i, rd_i, comp, div;
    logic [7:0] addr_i, wdata_i, e1, ex, r, d;
    logic [4:0] cid;
    wire  [7:0] rdata_o, p1i, p2i, p3i, p4i, p1o, p2o, p3o, p4o, p1e, p2e, p3e, p4e, pu2, pu3, pu4;
    wire        irq;
    integer     failures, tests_run, seed, i, n;
    logic [7:0] ra [10] = '{8'h90, 8'h93, 8'h9e, 8'h9f, 8'ha2, 8'ha0, 8'ha6, 8'ha7, 8'h95, 8'h92};
    logic [7:0] rv [10] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    pie_port_io dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .port_one_pin_i(p1i), .port_one_pin_o(p1o), .port_one_pin_oe_o(p1e),
        .port_two_pin_i(p2i), .port_two_pin_o(p2o), .port_two_pin_oe_o(p2e), .port_two_pullup_o(pu2),
        .port_three_pin_i(p3i), .port_three_pin_o(p3o), .port_three_pin_oe_o(p3e), .port_three_pullup_o(pu3),
        .port_four_pin_i(p4i), .port_four_pin_o(p4o), .port_four_pin_oe_o(p4e), .port_four_pullup_o(pu4),
        .caller_id_event_flag_i(cid), .comparator_result_bit_i(comp), .divider_overflow_flag_i(div), .irq_o(irq));
    pie_pin_model m1 (.oe_i(p1e), .out_i(p1o), .pu_i(8'h00), .ext_i(e1), .lvl_o(p1i));
    pie_pin_model m2 (.oe_i(p2e), .out_i(p2o), .pu_i(pu2), .ext_i(ex), .lvl_o(p2i));
    pie_pin_model m3 (.oe_i(p3e), .out_i(p3o), .pu_i(pu3), .ext_i(ex), .lvl_o(p3i));
    pie_pin_model m4 (.oe_i(p4e), .out_i(p4o), .pu_i(pu4), .ext_i(ex), .lvl_o(p4i));
    task complete_run;
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Input lines show the pin, output lines the latch
    function automatic logic [7:0] p1_exp(input logic [7:0] pin, input logic [7:0] dir, input logic [7:0] lat);
        return (pin & dir) | (lat & ~dir);
    endfunction
    task chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    // One event at a time so the flag and status bit can be tied to it
    task ev(input integer k);
        @(posedge clk_sys_i);
        case (k)
            0: e1 <= 8'hfb;
            1: e1 <= 8'hbf;
            2: cid <= 5'h04;
            3: div <= 1'b1;
            default: comp <= 1'b1;
        endcase
        repeat (3) @(posedge clk_sys_i);
        cid <= 5'h00;
        div <= 1'b0;
        #1;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk_sys_i);
            #1;
            n++;
            if (n > 20) begin
                failures++;
                complete_run;
            end
        end
        rd(`PIE_ADDR_EVT_FLAGS, 8'h01 << k);
        if (k < 2) rd(`PIE_ADDR_P1_STATUS, (k == 0) ? 8'h04 : 8'h40);
        e1 <= 8'hff;
        comp <= 1'b0;
        wr(`PIE_ADDR_P1_STATUS, 8'hff);
        wr(`PIE_ADDR_EVT_FLAGS, 8'hff);
        rd(`PIE_ADDR_P1_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h00);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        {nrst_i, wr_i, rd_i, comp, div, cid, addr_i, wdata_i} = '0;
        {e1, ex} = 16'hffff;
        {failures, tests_run, seed} = {32'd0, 32'd0, 32'd52};
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (i = 0; i < 10; i++) rd(ra[i], rv[i]);
        // Irq enables stay clear here, so random pin edges only touch status
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            d = $random(seed);
            e1 <= $random(seed);
            wr(`PIE_ADDR_P1_DIR, r);
            wr(`PIE_ADDR_P1_DATA, d);
            wr(`PIE_ADDR_P2_PULLUP, r);
            wr(`PIE_ADDR_P4_PULLUP, d);
            wr(`PIE_ADDR_P2_DIR, d);
            wr(`PIE_ADDR_IRQ_MASK, r);
            wr(`PIE_ADDR_P3_DATA, d);
            wr(`PIE_ADDR_P3_PULLUP, r);
            repeat (3) @(posedge clk_sys_i);
            rd(`PIE_ADDR_P1_DATA, p1_exp(e1, r, d));
            rd(`PIE_ADDR_P4_PULLUP, d);
            rd(`PIE_ADDR_IRQ_MASK, r & 8'h1f);
            rd(`PIE_ADDR_P3_DATA, d);
            chk(p2e, ~d);
            chk(pu2, r);
            chk(p1e, ~r);
            chk(p2o, 8'hff);
            chk(p3e, ~d);
            chk(p3o, d);
            chk(pu3, r);
        end
        wr(`PIE_ADDR_P4_DIR, 8'h00);
        #1 chk(p4e, 8'hff);
        chk(p4o, 8'hff);
        e1 <= 8'hff;
        wr(`PIE_ADDR_P1_DIR, 8'hff);
        repeat (4) @(posedge clk_sys_i);
        wr(`PIE_ADDR_P1_STATUS, 8'hff);
        wr(`PIE_ADDR_EVT_FLAGS, 8'hff);
        wr(`PIE_ADDR_P1_IRQEN, 8'hff);
        wr(`PIE_ADDR_IRQ_MASK, 8'h1f);
        for (i = 0; i < 5; i++) ev(i);
        complete_run;
    end
endmodule
bind pie_port_io pie_port_io_properties u_chk (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .port_one_pin_o, .port_one_pin_oe_o, .port_two_pin_oe_o, .port_four_pin_oe_o, .port_two_pullup_o,
    .port_four_pullup_o, .irq_o);
